// *** src/tw8_timer.sv ***
// Strobed register access was decided locally.
`timescale 1ns/1ps
`default_nettype none
module tw8_timer (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire tw8_pkg::tw8_bus_req_t bus_req,
    output logic [7:0] rdata,
    input wire logic ext_clk_pin,
    output logic compare_output_pin_o,
    output logic compare_output_pin_oe,
    output logic overflow_flag,
    output logic compare_match_flag
);
    import tw8_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // effect of a compare match for a non-PWM output mode
    function automatic logic match_action(input logic [1:0] com,
                                          input logic cur);
        logic res;
        res = cur;
        unique case (com)
            2'h0: res = cur;
            2'h1: res = ~cur;
            2'h2: res = 1'b0;
            2'h3: res = 1'b1;
        endcase
        return res;
    endfunction

    // prescaler tap selection for the internal clock selects
    function automatic logic prescale_tap(input logic [9:0] pre,
                                          input logic [9:0] mask);
        return (pre & mask) == mask;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // registers and decode

    logic [7:0] ctrl_reg;
    logic [7:0] ocr_buf_reg;
    logic [7:0] ocr_active_reg;
    logic [7:0] count_reg;
    logic count_up_reg;
    logic block_reg;
    logic pend_reg;
    logic oc_reg;
    logic [1:0] port_reg;
    logic ovf_reg;
    logic cmp_reg;
    logic [7:0] rdata_reg;
    logic pin_o_reg;
    logic pin_oe_reg;
    logic [PRESCALE_W-1:0] prescale_reg;
    logic [2:0] sync_reg;
    logic ext_level_reg;

    tw8_mode_t mode;
    logic [1:0] com;
    logic [2:0] clk_sel;
    logic pwm;
    logic [7:0] ocr_eff;
    logic tick;
    logic ext_rise;
    logic ext_fall;
    logic match;
    logic count_wr;
    logic force_wr;
    logic top_phase;
    logic bottom_phase;
    logic fast_wrap;
    logic ovf_set;

    // two mode bits sit apart in the control register
    assign mode = tw8_mode_t'({ctrl_reg[MODE_HIGH_BIT],
                               ctrl_reg[MODE_LOW_BIT]});
    assign com = ctrl_reg[COM_HIGH_BIT:COM_LOW_BIT];
    assign clk_sel = ctrl_reg[CS_MSB:0];
    assign pwm = (mode == TW8_PHASE) || (mode == TW8_FAST);
    assign count_wr = bus_req.wr && (bus_req.addr == COUNT_OFS);
    // the mode low bit of the written value decides if force is live
    assign force_wr = bus_req.wr && (bus_req.addr == CTRL_OFS)
                      && bus_req.wdata[FORCE_BIT]
                      && !bus_req.wdata[MODE_LOW_BIT];

    ////////////////////////////////////////////////////////////////////////
    // clock select: prescaler and external pin

    // free running prescaler; every tap is a one-cycle enable
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            prescale_reg <= PRESCALE_RESET;
        end else begin
            prescale_reg <= prescale_reg + 10'h001;
        end
    end

    // pin synchroniser; a change counts once stages two and three agree
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sync_reg <= SYNC_RESET;
            ext_level_reg <= 1'b0;
        end else begin
            sync_reg <= {sync_reg[1:0], ext_clk_pin};
            if (sync_reg[1] == sync_reg[2]) begin
                ext_level_reg <= sync_reg[2];
            end
        end
    end

    assign ext_rise = (sync_reg[1] == sync_reg[2]) && sync_reg[2]
                      && !ext_level_reg;
    assign ext_fall = (sync_reg[1] == sync_reg[2]) && !sync_reg[2]
                      && ext_level_reg;

    // tick acts only as a count enable, never as a clock
    always_comb begin
        tick = 1'b0;
        unique case (clk_sel)
            CS_STOP: tick = 1'b0;
            CS_DIV1: tick = 1'b1;
            CS_DIV8: tick = prescale_tap(prescale_reg, DIV8_MASK);
            CS_DIV64: tick = prescale_tap(prescale_reg, DIV64_MASK);
            CS_DIV256: tick = prescale_tap(prescale_reg, DIV256_MASK);
            CS_DIV1024: tick = prescale_tap(prescale_reg, DIV1024_MASK);
            CS_EXT_FALL: tick = ext_fall;
            CS_EXT_RISE: tick = ext_rise;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // counter

    // non-PWM modes compare against the written value at once
    assign ocr_eff = pwm ? ocr_active_reg : ocr_buf_reg;
    assign match = tick && !block_reg && (count_reg == ocr_eff);
    assign top_phase = tick && (mode == TW8_PHASE) && count_up_reg
                       && (count_reg == MAX);
    assign bottom_phase = tick && (mode == TW8_PHASE) && !count_up_reg
                          && (count_reg == BOTTOM);
    assign fast_wrap = tick && (mode == TW8_FAST) && (count_reg == MAX);

    // dual slope in phase mode gives 0..max..1, 510 ticks a period
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            count_reg <= COUNT_RESET;
            count_up_reg <= 1'b1;
        end else if (count_wr) begin
            count_reg <= bus_req.wdata;
        end else if (tick) begin
            unique case (mode)
                TW8_PHASE: begin
                    if (count_up_reg) begin
                        if (count_reg == MAX) begin
                            count_up_reg <= 1'b0;
                            count_reg <= MAX - 8'h01;
                        end else begin
                            count_reg <= count_reg + 8'h01;
                        end
                    end else if (count_reg == BOTTOM) begin
                        count_up_reg <= 1'b1;
                        count_reg <= BOTTOM + 8'h01;
                    end else begin
                        count_reg <= count_reg - 8'h01;
                    end
                end
                TW8_CTC: begin
                    count_reg <= match ? BOTTOM : count_reg + 8'h01;
                    count_up_reg <= 1'b1;
                end
                TW8_NORMAL, TW8_FAST: begin
                    count_reg <= count_reg + 8'h01;
                    count_up_reg <= 1'b1;
                end
            endcase
        end
    end

    // a counter write hides the match on the following tick
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            block_reg <= 1'b0;
        end else if (count_wr) begin
            block_reg <= 1'b1;
        end else if (tick) begin
            block_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // compare value buffering

    // PWM modes load at top or bottom so a period is never torn
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ocr_buf_reg <= COMPARE_RESET;
            ocr_active_reg <= COMPARE_RESET;
        end else begin
            if (bus_req.wr && (bus_req.addr == COMPARE_OFS)) begin
                ocr_buf_reg <= bus_req.wdata;
            end
            if (!pwm || top_phase || fast_wrap) begin
                ocr_active_reg <= ocr_buf_reg;
            end
        end
    end

    // remember a missed up-count match until the next bottom
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pend_reg <= 1'b0;
        end else if (top_phase && (ocr_active_reg == MAX)
                     && (ocr_buf_reg != MAX)) begin
            pend_reg <= 1'b1;
        end else if (count_wr && (mode == TW8_PHASE)
                     && (bus_req.wdata > ocr_eff)) begin
            pend_reg <= 1'b1;
        end else if (bottom_phase) begin
            pend_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // waveform generator

    // force beats a same-cycle match; com bits come from the write
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            oc_reg <= 1'b0;
        end else if (force_wr) begin
            oc_reg <= match_action(bus_req.wdata[COM_HIGH_BIT:COM_LOW_BIT],
                                   oc_reg);
        end else begin
            unique case (mode)
                TW8_NORMAL, TW8_CTC: begin
                    if (match) begin
                        oc_reg <= match_action(com, oc_reg);
                    end
                end
                TW8_FAST: begin
                    if (com[1]) begin
                        if (fast_wrap) begin
                            oc_reg <= ~com[0];
                        end else if (match && (ocr_eff != MAX)) begin
                            oc_reg <= com[0];
                        end
                    end
                end
                TW8_PHASE: begin
                    if (com[1]) begin
                        if (ocr_eff == MAX) begin
                            if (top_phase) begin
                                oc_reg <= ~com[0];
                            end
                        end else if (match) begin
                            // a match at bottom counts as up-counting
                            oc_reg <= (count_up_reg || count_reg == BOTTOM)
                                      ? com[0] : ~com[0];
                        end else if (bottom_phase && pend_reg) begin
                            oc_reg <= com[0];
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flags: hardware set wins over a write-one clear

    // phase mode flags at bottom, the other modes at max
    assign ovf_set = tick && ((mode == TW8_PHASE)
                     ? (!count_up_reg && count_reg == BOTTOM)
                     : (count_reg == MAX));

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ovf_reg <= 1'b0;
            cmp_reg <= 1'b0;
        end else begin
            if (ovf_set) begin
                ovf_reg <= 1'b1;
            end else if (bus_req.wr && (bus_req.addr == FLAG_OFS)
                         && bus_req.wdata[OVF_BIT]) begin
                ovf_reg <= 1'b0;
            end
            // only a counted match flags; a forced one never does
            if (match) begin
                cmp_reg <= 1'b1;
            end else if (bus_req.wr && (bus_req.addr == FLAG_OFS)
                         && bus_req.wdata[CMP_BIT]) begin
                cmp_reg <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control, port and read registers

    // force bit is never stored, so it reads back as zero
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= CTRL_RESET;
            port_reg <= PORT_RESET;
        end else begin
            if (bus_req.wr && (bus_req.addr == CTRL_OFS)) begin
                ctrl_reg <= {1'b0, bus_req.wdata[6:0]};
            end
            if (bus_req.wr && (bus_req.addr == PORT_OFS)) begin
                port_reg <= bus_req.wdata[1:0];
            end
        end
    end

    // read data stand for one cycle only; unmapped reads give zero
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= READ_IDLE;
        end else if (bus_req.rd) begin
            unique case (bus_req.addr)
                CTRL_OFS: rdata_reg <= ctrl_reg;
                FLAG_OFS: rdata_reg <= {6'h00, cmp_reg, ovf_reg};
                COUNT_OFS: rdata_reg <= count_reg;
                COMPARE_OFS: rdata_reg <= ocr_buf_reg;
                PORT_OFS: rdata_reg <= {6'h00, port_reg};
                default: rdata_reg <= READ_IDLE;
            endcase
        end else begin
            rdata_reg <= READ_IDLE;
        end
    end

    // compare output takes the pin over; direction bit gates the driver
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pin_o_reg <= 1'b0;
            pin_oe_reg <= 1'b0;
        end else begin
            pin_o_reg <= (com != 2'h0) ? oc_reg
                         : port_reg[PORT_DATA_BIT];
            pin_oe_reg <= port_reg[DIR_BIT];
        end
    end

    assign rdata = rdata_reg;
    assign compare_output_pin_o = pin_o_reg;
    assign compare_output_pin_oe = pin_oe_reg;
    assign overflow_flag = ovf_reg;
    assign compare_match_flag = cmp_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks

    localparam int PHASE_TICKS = PWM_PERIOD - 1;
    logic [8:0] period_ticks_reg;
    logic period_clean_reg;

    // ticks between two bottoms of an undisturbed phase period
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            period_ticks_reg <= 9'h000;
            period_clean_reg <= 1'b0;
        end else if (count_wr || mode != TW8_PHASE) begin
            period_clean_reg <= 1'b0;
        end else if (bottom_phase) begin
            period_ticks_reg <= 9'h000;
            period_clean_reg <= 1'b1;
        end else if (tick) begin
            period_ticks_reg <= period_ticks_reg + 9'h001;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    a_phase_top_turn: assert property (
        top_phase && !count_wr |=> count_reg == 8'hFE && !count_up_reg)
        else $error("phase mode did not turn at max");
    a_phase_period_len: assert property (
        bottom_phase && period_clean_reg && !count_wr
        |-> period_ticks_reg == 9'(PHASE_TICKS))
        else $error("phase period is not 510 ticks");
    a_phase_ovf_bottom: assert property (
        bottom_phase |=> ovf_reg)
        else $error("overflow flag missing at phase bottom");
    a_force_toggle_out: assert property (
        force_wr && bus_req.wdata[COM_HIGH_BIT:COM_LOW_BIT] == 2'h1
        |=> oc_reg != $past(oc_reg))
        else $error("forced toggle did not change output");
    a_force_no_flag: assert property (
        force_wr && !match && !cmp_reg |=> !cmp_reg)
        else $error("forced compare set the flag");
    a_force_reads_zero: assert property (
        bus_req.rd && bus_req.addr == CTRL_OFS |=> !rdata[FORCE_BIT])
        else $error("force bit read back as one");
    a_ctc_clear_count: assert property (
        mode == TW8_CTC && match && !count_wr ##0 !bus_req.wr
        |=> count_reg == BOTTOM)
        else $error("clear-on-match did not clear counter");
    a_fast_bottom_lvl: assert property (
        fast_wrap && com[1] && !force_wr
        |=> oc_reg == !$past(ctrl_reg[COM_LOW_BIT]))
        else $error("fast mode bottom level wrong");
    a_pin_override: assert property (
        com != 2'h0 |=> compare_output_pin_o == $past(oc_reg))
        else $error("compare output did not reach the pin");
    a_nonpwm_clear: assert property (
        !pwm && match && com == 2'h2 && !force_wr |=> !oc_reg)
        else $error("clear on match failed");
endmodule
`default_nettype wire

// *** src/tw8_pkg.sv ***
`default_nettype none
package tw8_pkg;
    // register offsets on the plain register port
    localparam logic [7:0] CTRL_OFS = 8'h24;
    localparam logic [7:0] FLAG_OFS = 8'h25;
    localparam logic [7:0] COUNT_OFS = 8'h26;
    localparam logic [7:0] COMPARE_OFS = 8'h27;
    localparam logic [7:0] PORT_OFS = 8'h28;
    // values after reset
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] COMPARE_RESET = 8'h00;
    localparam logic [1:0] PORT_RESET = 2'h0;
    localparam logic [7:0] READ_IDLE = 8'h00;
    // control register fields
    localparam int FORCE_BIT = 7;
    localparam int MODE_LOW_BIT = 6;
    localparam int COM_HIGH_BIT = 5;
    localparam int COM_LOW_BIT = 4;
    localparam int MODE_HIGH_BIT = 3;
    localparam int CS_MSB = 2;
    // flag and port register fields
    localparam int OVF_BIT = 0;
    localparam int CMP_BIT = 1;
    localparam int DIR_BIT = 0;
    localparam int PORT_DATA_BIT = 1;
    // counter landmarks
    localparam logic [7:0] BOTTOM = 8'h00;
    localparam logic [7:0] MAX = 8'hFF;
    localparam int PWM_PERIOD = 510;
    // clock select codes and prescaler
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    localparam int PRESCALE_W = 10;
    localparam logic [9:0] DIV8_MASK = 10'h007;
    localparam logic [9:0] DIV64_MASK = 10'h03F;
    localparam logic [9:0] DIV256_MASK = 10'h0FF;
    localparam logic [9:0] DIV1024_MASK = 10'h3FF;
    localparam logic [9:0] PRESCALE_RESET = 10'h000;
    localparam logic [2:0] SYNC_RESET = 3'h0;

    typedef enum logic [1:0] {
        TW8_NORMAL,
        TW8_PHASE,
        TW8_CTC,
        TW8_FAST
    } tw8_mode_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tw8_bus_req_t;
endpackage
`default_nettype wire

// *** dv/tw8_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////
// compare helper: counts every check, reports and counts each mismatch
`define CHK(nm, exp, got) begin \
    checks++; \
    if ((got) !== (exp)) begin \
        error_cnt++; \
        $display("unexpected %s: expected %0h, seen %0h", nm, exp, got); \
    end \
end

module testbench;
    import tw8_pkg::*;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    tw8_bus_req_t bus_req = '0;
    logic [7:0] rdata;
    logic ext_clk_pin = 1'b0;
    logic pin_o;
    logic pin_oe;
    logic ovf;
    logic cmf;
    int error_cnt = 0;
    int checks = 0;
    int seed = 32'h1c744569;
    logic [15:0] exp_q[$];
    logic rd_seen = 1'b0;
    // forced strobes with the timer stopped, and the level each leaves
    logic [7:0] fc [5] = '{8'hB0, 8'h90, 8'h90, 8'hA8, 8'h98};
    logic fe [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
    // waveform table: control, compare, window, expected high cycles
    logic [7:0] wc [11] = '{8'h61, 8'h71, 8'h61, 8'h61, 8'h71, 8'h69,
        8'h79, 8'h69, 8'h6A, 8'h6F, 8'h19};
    logic [7:0] wo [11] = '{8'h80, 8'h80, 8'h00, 8'hFF, 8'h00, 8'h40,
        8'h40, 8'hFF, 8'h40, 8'h40, 8'h09};
    int ww [11] = '{510, 510, 510, 510, 510, 256, 256, 256, 2048, 4096, 200};
    int wh [11] = '{256, 254, 0, 510, 510, 64, 192, 256, 512, 1024, 100};
    // clock selects the table leaves out, and one full toggle period each
    logic [2:0] ct [4] = '{CS_DIV64, CS_DIV256, CS_DIV1024, CS_EXT_FALL};
    int cw [4] = '{256, 1024, 4096, 64};

    ////////////////////////////////////////////////////////////////////////
    // 200 MHz clock
    always #2.5 ref_clk = ~ref_clk;

    // external count pin: one rising edge every 16 cycles, slow enough
    // for the three-flop filter to see each level
    always begin
        repeat (8) @(posedge ref_clk);
        ext_clk_pin <= ~ext_clk_pin;
    end

    tw8_timer u_dut (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .bus_req(bus_req),
        .rdata(rdata),
        .ext_clk_pin(ext_clk_pin),
        .compare_output_pin_o(pin_o),
        .compare_output_pin_oe(pin_oe),
        .overflow_flag(ovf),
        .compare_match_flag(cmf)
    );

    ////////////////////////////////////////////////////////////////////////
    // read monitor: data stand only in the cycle after the strobe
    always @(posedge ref_clk) begin
        logic [15:0] e;
        if (rd_seen) begin
            e = exp_q.pop_front();
            `CHK("read data", e[7:0], rdata)
        end
        rd_seen <= bus_req.rd;
    end

    // one-cycle write, then an idle cycle so strobes never double up
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
        @(posedge ref_clk);
    endtask

    task automatic bus_rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back({a, e});
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
        @(posedge ref_clk);
    endtask

    // high-cycle count over one window; tolerance covers the phase of
    // the window against the period, not a wrong duty
    task automatic measure(input logic [7:0] ctrl, input logic [7:0] ocr,
                           input int win, input int hi);
        int n;
        int tol;
        n = 0;
        tol = 2 + win / 256;
        bus_wr(COMPARE_OFS, ocr);
        bus_wr(CTRL_OFS, ctrl);
        repeat (2 * win) @(posedge ref_clk);
        repeat (win) begin
            @(posedge ref_clk);
            if (pin_o === 1'b1) n++;
        end
        `CHK("high cycles", 1'b1, (n >= hi - tol && n <= hi + tol))
        $display("test waveform %0h/%0h done, high %0d", ctrl, ocr, n);
    endtask

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        logic [7:0] v;
        int n;
        repeat (10) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        bus_rd(CTRL_OFS, CTRL_RESET);
        bus_rd(COUNT_OFS, COUNT_RESET);
        bus_rd(COMPARE_OFS, COMPARE_RESET);
        bus_rd(8'h3C, READ_IDLE);
        $display("test reset done");
        // random control values with the timer stopped
        repeat (6) begin
            v = 8'($random(seed));
            v[2:0] = CS_STOP;
            if (v[MODE_LOW_BIT]) v[FORCE_BIT] = 1'b0;
            bus_wr(CTRL_OFS, v);
            bus_rd(CTRL_OFS, v & 8'h7F);
            v = 8'($random(seed));
            bus_wr(COMPARE_OFS, v);
            bus_rd(COMPARE_OFS, v);
        end
        $display("test readback done");
        // with output mode zero the port data bit owns the pin
        bus_wr(CTRL_OFS, 8'h00);
        bus_wr(PORT_OFS, 8'h03);
        repeat (2) @(posedge ref_clk);
        `CHK("pin enable", 1'b1, pin_oe)
        `CHK("pin port data", 1'b1, pin_o)
        bus_wr(PORT_OFS, 8'h01);
        repeat (2) @(posedge ref_clk);
        `CHK("pin port data", 1'b0, pin_o)
        $display("test port done");
        // forced matches must neither flag nor clear the counter
        bus_wr(COUNT_OFS, 8'h05);
        bus_wr(COMPARE_OFS, 8'h05);
        for (int i = 0; i < 5; i++) begin
            bus_wr(CTRL_OFS, fc[i]);
            repeat (2) @(posedge ref_clk);
            `CHK("forced level", fe[i], pin_o)
        end
        `CHK("match flag", 1'b0, cmf)
        bus_rd(COUNT_OFS, 8'h05);
        bus_rd(CTRL_OFS, 8'h18);
        $display("test force done");
        // dual-slope period between two overflow flags
        bus_wr(CTRL_OFS, 8'h41);
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (ovf !== 1'b1 && n < 1200);
        bus_wr(FLAG_OFS, 8'h03);
        n = 2;
        do begin
            @(posedge ref_clk);
            n++;
        end while (ovf !== 1'b1 && n < 1200);
        `CHK("phase period", PWM_PERIOD, n)
        $display("test phase period done");
        for (int i = 0; i < 11; i++) begin
            measure(wc[i], wo[i], ww[i], wh[i]);
        end
        // CTC with compare 1 toggles every second tick, so the output
        // is high for half of each window; counter parked at zero first
        for (int i = 0; i < 4; i++) begin
            bus_wr(CTRL_OFS, 8'h18);
            bus_wr(COUNT_OFS, 8'h00);
            measure({5'h03, ct[i]}, 8'h01, cw[i], cw[i] / 2);
        end
        // normal mode, clear on match: a forced high level gets cleared
        bus_wr(CTRL_OFS, 8'hB0);
        bus_wr(FLAG_OFS, 8'h03);
        bus_rd(FLAG_OFS, 8'h00);
        `CHK("forced high", 1'b1, pin_o)
        measure(8'h21, 8'h40, 256, 0);
        bus_rd(FLAG_OFS, 8'h03);
        // compare leaving max: the output drops at bottom with no match,
        // otherwise the low half would be lopsided around bottom
        bus_wr(COMPARE_OFS, 8'hFF);
        bus_wr(CTRL_OFS, 8'h61);
        bus_wr(FLAG_OFS, 8'h03);
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin
                @(posedge ref_clk);
                n++;
            end while (ovf !== 1'b1 && n < 1200);
            `CHK("bottom reached", 1'b1, ovf)
            if (k == 0) begin
                `CHK("steady high", 1'b1, pin_o)
                bus_wr(COMPARE_OFS, 8'h80);
                bus_wr(FLAG_OFS, 8'h03);
            end
        end
        repeat (2) @(posedge ref_clk);
        `CHK("level at bottom", 1'b0, pin_o)
        $display("test symmetry done");
        print_verdict();
    end

    // watchdog well beyond the expected run of about 48000 cycles
    initial begin
        repeat (80000) @(posedge ref_clk);
        error_cnt++;
        print_verdict();
    end
endmodule
`default_nettype wire
